// ===== rtl/dchs_pkg.sv
// Package of constants and types for the dog and count homing sequencer.
`default_nettype none
package dchs_pkg;
	// ==========================================================
	// Register map, word offsets on the plain register port.
	localparam logic [3:0] DCHS_ADDR_CTRL = 4'h0;
	localparam logic [3:0] DCHS_ADDR_METHOD = 4'h1;
	localparam logic [3:0] DCHS_ADDR_HOME_SPD = 4'h2;
	localparam logic [3:0] DCHS_ADDR_CREEP_SPD = 4'h3;
	localparam logic [3:0] DCHS_ADDR_SHIFT = 4'h4;
	localparam logic [3:0] DCHS_ADDR_ACCEL = 4'h5;
	localparam logic [3:0] DCHS_ADDR_HOME_POS = 4'h6;
	localparam logic [3:0] DCHS_ADDR_POST_DIST = 4'h7;
	localparam logic [3:0] DCHS_ADDR_STATUS = 4'h8;
	localparam logic [3:0] DCHS_ADDR_POS = 4'h9;
	localparam logic [3:0] DCHS_ADDR_REV_POS = 4'hA;
	// ==========================================================
	// Field positions in the method register.
	localparam int DCHS_METHOD_LSB = 0;
	localparam int DCHS_METHOD_MSB = 3;
	localparam int DCHS_DIR_BIT = 4;
	localparam int DCHS_POL_BIT = 8;
	localparam logic [3:0] DCHS_METHOD_DOG = 4'h0;
	localparam logic [3:0] DCHS_METHOD_COUNT = 4'h1;
	// Field positions in the status register.
	localparam int DCHS_ST_BUSY_BIT = 0;
	localparam int DCHS_ST_DONE_BIT = 1;
	localparam int DCHS_ST_ERR_BIT = 2;
	localparam int DCHS_ST_DOG_BIT = 3;
	// Control register: bit 0 clears the done flag.
	localparam int DCHS_CTRL_CLR_BIT = 0;
	// ==========================================================
	// Reset values.
	localparam logic [31:0] DCHS_RST_ZERO = 32'h0000_0000;
	localparam logic [31:0] DCHS_RST_SPEED = 32'h0000_0010;
	localparam logic [31:0] DCHS_RST_CREEP = 32'h0000_0002;
	localparam logic [31:0] DCHS_RST_ACCEL = 32'h0000_0001;
	// ==========================================================
	// Timing: the switch must stand for this long in the count method.
	localparam int DCHS_CLK_MHZ = 100;
	localparam int DCHS_DOG_MIN_MS = 10;
	localparam int DCHS_DOG_MIN_CYC = DCHS_DOG_MIN_MS * 1000 * DCHS_CLK_MHZ;
	// ==========================================================
	// Sequencer states, Gray coded along the main path.
	typedef enum logic [2:0] {
		DCHS_IDLE = 3'h0,
		DCHS_FAST = 3'h1,
		DCHS_ON_DOG = 3'h3,
		DCHS_SEEK_Z = 3'h2,
		DCHS_SHIFT = 3'h6,
		DCHS_STOP = 3'h7,
		DCHS_DONE = 3'h5
	} dchs_state_t;
endpackage
`default_nettype wire

// ===== rtl/dchs_homing_seq.sv
// Dog and count homing sequencer with speed ramp and register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Method digit zero selects dog homing.
// - Method digit one selects count homing.
// - Homing speed until switch detected.
// - Creep speed after switch detection.
// - Dog: home at first index past rear.
// - Dog: shift distance beyond that index.
// - All speed changes use homing ramp.
// - Load position with home data at end.
// - Count: travel distance, then next index.
// - Count: shift measured from that index.
// - Within-revolution position readable as status.
// - Direction 0 increments, 1 decrements.
// - Polarity 0 detects off, 1 on.
// - Index pulse used internally, never output.
module dchs_homing_seq #(
	parameter int DOG_MIN_CYC = dchs_pkg::DCHS_DOG_MIN_CYC,
	parameter int REV_COUNTS = 4096
) (
	input wire logic core_clk_i, // System clock, 100 MHz.
	input wire logic resetn_i, // Synchronous reset, active low.
	input wire logic auto_manual_select_i, // Manual mode selected when high.
	input wire logic homing_command_i, // One-cycle pulse from program execution.
	input wire logic dog_i, // Proximity switch pin.
	input wire logic enc_index_i, // Encoder index pin, once per revolution.
	input wire logic enc_step_i, // Encoder count pulse, same clock.
	input wire logic [3:0] addr_i, // Register word address.
	input wire logic [31:0] wdata_i, // Register write data.
	input wire logic wr_i, // Write strobe.
	input wire logic rd_i, // Read strobe.
	output logic [31:0] rdata_o, // Read data, one cycle after rd_i.
	output logic [31:0] speed_o, // Commanded speed magnitude.
	output logic dir_neg_o, // High for decreasing addresses.
	output logic busy_o, // Homing run in progress.
	output logic done_o // Homing complete.
);
	import dchs_pkg::*;

	// ==========================================================
	// Configuration registers.
	logic [31:0] method_reg, method_next;
	logic [31:0] hspd_reg, hspd_next, cspd_reg, cspd_next;
	logic [31:0] shift_reg, shift_next, accel_reg, accel_next;
	logic [31:0] hpos_reg, hpos_next, post_reg, post_next;
	logic clr_done;

	// Software writes; the clear bit is a pulse, not stored.
	always_comb begin
		method_next = method_reg;
		hspd_next = hspd_reg;
		cspd_next = cspd_reg;
		shift_next = shift_reg;
		accel_next = accel_reg;
		hpos_next = hpos_reg;
		post_next = post_reg;
		clr_done = 1'b0;
		if (wr_i) begin
			if (addr_i == DCHS_ADDR_CTRL) begin
				clr_done = wdata_i[DCHS_CTRL_CLR_BIT];
			end else if (addr_i == DCHS_ADDR_METHOD) begin
				method_next = wdata_i;
			end else if (addr_i == DCHS_ADDR_HOME_SPD) begin
				hspd_next = wdata_i;
			end else if (addr_i == DCHS_ADDR_CREEP_SPD) begin
				cspd_next = wdata_i;
			end else if (addr_i == DCHS_ADDR_SHIFT) begin
				shift_next = wdata_i;
			end else if (addr_i == DCHS_ADDR_ACCEL) begin
				accel_next = wdata_i;
			end else if (addr_i == DCHS_ADDR_HOME_POS) begin
				hpos_next = wdata_i;
			end else if (addr_i == DCHS_ADDR_POST_DIST) begin
				post_next = wdata_i;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			method_reg <= DCHS_RST_ZERO;
			hspd_reg <= DCHS_RST_SPEED;
			cspd_reg <= DCHS_RST_CREEP;
			shift_reg <= DCHS_RST_ZERO;
			accel_reg <= DCHS_RST_ACCEL;
			hpos_reg <= DCHS_RST_ZERO;
			post_reg <= DCHS_RST_ZERO;
		end else begin
			method_reg <= method_next;
			hspd_reg <= hspd_next;
			cspd_reg <= cspd_next;
			shift_reg <= shift_next;
			accel_reg <= accel_next;
			hpos_reg <= hpos_next;
			post_reg <= post_next;
		end
	end

	// ==========================================================
	// Pin synchronisers: three stages, a change counts once stages two and three agree.
	logic [2:0] dog_sync_reg, idx_sync_reg;
	logic dog_lvl_reg, dog_lvl_next, idx_lvl_reg, idx_lvl_next;

	always_comb begin
		dog_lvl_next = dog_lvl_reg;
		idx_lvl_next = idx_lvl_reg;
		if (dog_sync_reg[1] == dog_sync_reg[2]) begin
			dog_lvl_next = dog_sync_reg[2];
		end
		if (idx_sync_reg[1] == idx_sync_reg[2]) begin
			idx_lvl_next = idx_sync_reg[2];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			dog_sync_reg <= 3'h0;
			idx_sync_reg <= 3'h0;
			dog_lvl_reg <= 1'b0;
			idx_lvl_reg <= 1'b0;
		end else begin
			dog_sync_reg <= {dog_sync_reg[1:0], dog_i};
			idx_sync_reg <= {idx_sync_reg[1:0], enc_index_i};
			dog_lvl_reg <= dog_lvl_next;
			idx_lvl_reg <= idx_lvl_next;
		end
	end

	// Switch detection follows the polarity bit; the index acts on its rising edge.
	logic dog_det, idx_rise;
	assign dog_det = method_reg[DCHS_POL_BIT] ? dog_lvl_reg : ~dog_lvl_reg;
	assign idx_rise = idx_lvl_next & ~idx_lvl_reg;

	// ==========================================================
	// Sequencer state.
	dchs_state_t state_reg, state_next;
	logic [31:0] target_reg, target_next, dist_reg, dist_next;
	logic [31:0] pos_reg, pos_next, rev_reg, rev_next;
	logic [31:0] dogcnt_reg, dogcnt_next;
	logic done_reg, done_next, err_reg, err_next, dogseen_reg, dogseen_next;
	logic is_count, dir_neg;
	assign is_count = method_reg[DCHS_METHOD_MSB:DCHS_METHOD_LSB] == DCHS_METHOD_COUNT;
	assign dir_neg = method_reg[DCHS_DIR_BIT];

	// Steps the run; dist_reg counts encoder steps for the count and shift legs.
	always_comb begin
		state_next = state_reg;
		target_next = target_reg;
		dist_next = dist_reg;
		pos_next = pos_reg;
		rev_next = rev_reg;
		dogcnt_next = dogcnt_reg;
		done_next = done_reg;
		err_next = err_reg;
		dogseen_next = dogseen_reg;
		// Position tracking from encoder steps in the commanded direction.
		if (enc_step_i) begin
			pos_next = dir_neg_o ? pos_reg - 32'h1 : pos_reg + 32'h1;
			rev_next = (rev_reg == 32'(REV_COUNTS - 1)) ? 32'h0 : rev_reg + 32'h1;
			if (dist_reg != 32'h0) begin
				dist_next = dist_reg - 32'h1;
			end
		end
		if (idx_rise) begin
			rev_next = 32'h0;
		end
		// Done is sticky; a new completion wins over a software clear.
		if (clr_done) begin
			done_next = 1'b0;
		end
		case (state_reg)
			DCHS_IDLE: begin
				// Starts only on the command while manual mode is chosen and method is 0 or 1.
				if (homing_command_i && auto_manual_select_i) begin
					if (method_reg[DCHS_METHOD_MSB:DCHS_METHOD_LSB] == DCHS_METHOD_DOG ||
						is_count) begin
						state_next = DCHS_FAST;
						target_next = hspd_reg;
						done_next = 1'b0;
						err_next = 1'b0;
						dogseen_next = 1'b0;
					end else begin
						err_next = 1'b1;
					end
				end
			end
			DCHS_FAST: begin
				if (dog_det) begin
					state_next = DCHS_ON_DOG;
					target_next = cspd_reg;
					dist_next = post_reg;
					dogcnt_next = 32'h0;
				end
			end
			DCHS_ON_DOG: begin
				if (dog_det && dogcnt_reg != 32'(DOG_MIN_CYC)) begin
					dogcnt_next = dogcnt_reg + 32'h1;
				end
				if (is_count) begin
					// A switch dropping before its least time marks the run failed.
					if (!dog_det && dogcnt_reg != 32'(DOG_MIN_CYC)) begin
						err_next = 1'b1;
						state_next = DCHS_STOP;
						target_next = 32'h0;
					end else if (dist_reg == 32'h0) begin
						state_next = DCHS_SEEK_Z;
					end
				end else if (!dog_det) begin
					state_next = DCHS_SEEK_Z;
				end
			end
			DCHS_SEEK_Z: begin
				if (idx_rise) begin
					dist_next = shift_reg;
					state_next = DCHS_SHIFT;
				end
			end
			DCHS_SHIFT: begin
				if (dist_reg == 32'h0) begin
					state_next = DCHS_STOP;
					target_next = 32'h0;
				end
			end
			DCHS_STOP: begin
				if (speed_o == 32'h0) begin
					state_next = err_reg ? DCHS_IDLE : DCHS_DONE;
				end
			end
			DCHS_DONE: begin
				pos_next = hpos_reg;
				done_next = 1'b1;
				state_next = DCHS_IDLE;
			end
			default: state_next = DCHS_IDLE;
		endcase
		if (dog_det) begin
			dogseen_next = 1'b1;
		end
	end

	// Speed ramp: every change steps by at most the homing acceleration value.
	logic [31:0] speed_next;
	always_comb begin
		speed_next = speed_o;
		if (speed_o < target_reg) begin
			speed_next = (target_reg - speed_o > accel_reg) ? speed_o + accel_reg : target_reg;
		end else if (speed_o > target_reg) begin
			speed_next = (speed_o - target_reg > accel_reg) ? speed_o - accel_reg : target_reg;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			state_reg <= DCHS_IDLE;
			target_reg <= DCHS_RST_ZERO;
			dist_reg <= DCHS_RST_ZERO;
			pos_reg <= DCHS_RST_ZERO;
			rev_reg <= DCHS_RST_ZERO;
			dogcnt_reg <= DCHS_RST_ZERO;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			dogseen_reg <= 1'b0;
			speed_o <= DCHS_RST_ZERO;
			dir_neg_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			state_reg <= state_next;
			target_reg <= target_next;
			dist_reg <= dist_next;
			pos_reg <= pos_next;
			rev_reg <= rev_next;
			dogcnt_reg <= dogcnt_next;
			done_reg <= done_next;
			err_reg <= err_next;
			dogseen_reg <= dogseen_next;
			speed_o <= speed_next;
			dir_neg_o <= dir_neg;
			busy_o <= state_next != DCHS_IDLE;
			done_o <= done_next;
		end
	end

	// ==========================================================
	// Read port: data stand the cycle after the strobe; unmapped reads give zero.
	logic [31:0] rdata_next;
	always_comb begin
		rdata_next = 32'h0;
		if (rd_i) begin
			if (addr_i == DCHS_ADDR_METHOD) begin
				rdata_next = method_reg;
			end else if (addr_i == DCHS_ADDR_HOME_SPD) begin
				rdata_next = hspd_reg;
			end else if (addr_i == DCHS_ADDR_CREEP_SPD) begin
				rdata_next = cspd_reg;
			end else if (addr_i == DCHS_ADDR_SHIFT) begin
				rdata_next = shift_reg;
			end else if (addr_i == DCHS_ADDR_ACCEL) begin
				rdata_next = accel_reg;
			end else if (addr_i == DCHS_ADDR_HOME_POS) begin
				rdata_next = hpos_reg;
			end else if (addr_i == DCHS_ADDR_POST_DIST) begin
				rdata_next = post_reg;
			end else if (addr_i == DCHS_ADDR_STATUS) begin
				rdata_next[DCHS_ST_BUSY_BIT] = busy_o;
				rdata_next[DCHS_ST_DONE_BIT] = done_reg;
				rdata_next[DCHS_ST_ERR_BIT] = err_reg;
				rdata_next[DCHS_ST_DOG_BIT] = dogseen_reg;
			end else if (addr_i == DCHS_ADDR_POS) begin
				rdata_next = pos_reg;
			end else if (addr_i == DCHS_ADDR_REV_POS) begin
				rdata_next = rev_reg;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rdata_o <= DCHS_RST_ZERO;
		end else begin
			rdata_o <= rdata_next;
		end
	end
endmodule
`default_nettype wire

// ===== testbench/dchs_homing_seq_sva.sv
// Checker of the homing sequencer port behaviour.
`timescale 1ns/1ps
`default_nettype none
module dchs_homing_seq_sva
	import dchs_pkg::*;
(
	input wire logic core_clk_i, // Clock.
	input wire logic resetn_i, // Reset, active low.
	input wire logic auto_manual_select_i, // Manual select.
	input wire logic homing_command_i, // Start pulse.
	input wire logic [3:0] addr_i, // Address.
	input wire logic [31:0] wdata_i, // Write data.
	input wire logic wr_i, // Write strobe.
	input wire logic rd_i, // Read strobe.
	input wire logic [31:0] rdata_o, // Read data.
	input wire logic [31:0] speed_o, // Speed.
	input wire logic dir_neg_o, // Direction.
	input wire logic busy_o, // Busy.
	input wire logic done_o // Done.
);
	logic [31:0] accel_q;
	logic [31:0] hspd_q;
	// ==========
	// Shadow ramp step and top speed, so the bounds follow software.
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			accel_q <= DCHS_RST_ACCEL;
			hspd_q <= DCHS_RST_SPEED;
		end else if (wr_i && addr_i == DCHS_ADDR_ACCEL) begin
			accel_q <= wdata_i;
		end else if (wr_i && addr_i == DCHS_ADDR_HOME_SPD) begin
			hspd_q <= wdata_i;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	// ==========
	// Properties.
	sequence s_idle_cmd; homing_command_i && !busy_o; endsequence
	sequence s_clr; wr_i && addr_i == DCHS_ADDR_CTRL && wdata_i[DCHS_CTRL_CLR_BIT]; endsequence
	property p_manual; s_idle_cmd ##0 !auto_manual_select_i |=> !busy_o; endproperty
	property p_idle; !busy_o && !homing_command_i |=> !busy_o; endproperty
	property p_ramp;
		busy_o && $past(busy_o) |-> ((speed_o >= $past(speed_o)) ?
			speed_o - $past(speed_o) : $past(speed_o) - speed_o) <= accel_q;
	endproperty
	property p_cap; speed_o <= hspd_q; endproperty
	property p_stop; $rose(done_o) |-> speed_o == 32'h0 && $past(busy_o); endproperty
	property p_sticky;
		done_o && !homing_command_i &&
			!(wr_i && addr_i == DCHS_ADDR_CTRL && wdata_i[DCHS_CTRL_CLR_BIT]) |=> done_o;
	endproperty
	property p_clear; s_clr ##0 !busy_o |=> !done_o; endproperty
	property p_dir;
		wr_i && addr_i == DCHS_ADDR_METHOD |-> ##2 dir_neg_o == $past(wdata_i[DCHS_DIR_BIT], 2);
	endproperty
	property p_rd; !rd_i |=> rdata_o == 32'h0; endproperty
	a_manual: assert property (p_manual) else $error("start taken without manual select");
	a_idle: assert property (p_idle) else $error("run began without a command");
	a_ramp: assert property (p_ramp) else $error("speed step exceeds ramp");
	a_cap: assert property (p_cap) else $error("speed above homing speed");
	a_stop: assert property (p_stop) else $error("done without standstill");
	a_sticky: assert property (p_sticky) else $error("done dropped");
	a_clear: assert property (p_clear) else $error("done not cleared");
	a_dir: assert property (p_dir) else $error("direction differs from setting");
	a_rd: assert property (p_rd) else $error("read data outside read cycle");
endmodule
bind dchs_homing_seq dchs_homing_seq_sva u_sva (.core_clk_i, .resetn_i, .auto_manual_select_i,
	.homing_command_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .speed_o, .dir_neg_o,
	.busy_o, .done_o);
`default_nettype wire

// ===== testbench/dchs_axis_model.sv
// Behavioural axis: proximity switch and encoder facing the sequencer.
`timescale 1ns/1ps
`default_nettype none
module dchs_axis_model #(
	parameter int DOG_LO = 100,
	parameter int DOG_HI = 180
) (
	input wire logic core_clk_i, // Clock.
	input wire logic [31:0] speed_i, // Commanded speed.
	input wire logic dir_neg_i, // High moves down.
	input wire logic pol_i, // High: switch reads on over the cam.
	output logic dog_o, // Proximity switch.
	output logic enc_index_o, // Index, once per 64 counts.
	output logic enc_step_o // Count pulse.
);
	int pos = 1;
	int acc = 0;
	int acc_sum;
	logic on_dog;
	// One count per 64 units of speed, so creep is far slower than the approach.
	// All state moves by non-blocking assignment, so the pins never race the sampling edge.
	assign acc_sum = acc + int'(speed_i);
	always @(posedge core_clk_i) begin
		enc_step_o <= acc_sum >= 64;
		if (acc_sum >= 64) begin
			acc <= acc_sum - 64;
			pos <= dir_neg_i ? pos - 1 : pos + 1;
		end else begin
			acc <= acc_sum;
		end
	end
	// The cam is long, so the switch stands far beyond the minimum.
	assign on_dog = pos >= DOG_LO && pos <= DOG_HI;
	assign dog_o = pol_i ? on_dog : !on_dog;
	assign enc_index_o = pos % 64 == 0;
endmodule
`default_nettype wire

// ===== testbench/dchs_homing_seq_tb_top.sv
// Self-checking bench for the dog and count homing sequencer.
`timescale 1ns/1ps
`default_nettype none
module dchs_homing_seq_tb_top;
	import dchs_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic manual = 1'b1;
	logic cmd = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic pol = 1'b1;
	logic dog, idx, step, dir_neg, busy, done;
	logic [31:0] rdata, speed, v;
	int miscompares = 0;
	int n_tests = 0;
	dchs_homing_seq #(.DOG_MIN_CYC(20)) DUT (.core_clk_i(clk), .resetn_i(resetn),
		.auto_manual_select_i(manual), .homing_command_i(cmd), .dog_i(dog),
		.enc_index_i(idx), .enc_step_i(step), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .speed_o(speed), .dir_neg_o(dir_neg), .busy_o(busy),
		.done_o(done));
	dchs_axis_model u_axis (.core_clk_i(clk), .speed_i(speed), .dir_neg_i(dir_neg),
		.pol_i(pol), .dog_o(dog), .enc_index_o(idx), .enc_step_o(step));
	initial forever #5 clk = ~clk;
	// ==========
	// Shared tasks.
	task conclude;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task start(input logic [31:0] meth);
		wr_reg(DCHS_ADDR_METHOD, meth);
		cmd <= 1'b1;
		@(posedge clk);
		cmd <= 1'b0;
	endtask
	task wait_done;
		int i;
		for (i = 0; i < 20000 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (done !== 1'b1) begin
			chk({31'h0, done}, 32'h1);
			conclude();
		end
	endtask
	// ==========
	// Scenarios.
	task t_regs;
		rd_reg(DCHS_ADDR_HOME_SPD); chk(v, DCHS_RST_SPEED);
		rd_reg(DCHS_ADDR_CREEP_SPD); chk(v, DCHS_RST_CREEP);
		wr_reg(DCHS_ADDR_STATUS, 32'hF);
		// Polarity 0 after reset takes the idle low pin as the switch, so the seen bit is up.
		rd_reg(DCHS_ADDR_STATUS); chk(v, 32'h8);
		rd_reg(4'hF); chk(v, 32'h0);
	endtask
	task t_manual;
		@(posedge clk);
		manual <= 1'b0;
		start(32'h0000_0100);
		repeat (4) @(posedge clk);
		manual <= 1'b1;
		#1 chk({31'h0, busy}, 32'h0);
	endtask
	task t_dog;
		int i;
		wr_reg(DCHS_ADDR_HOME_POS, 32'h0000_1234);
		wr_reg(DCHS_ADDR_SHIFT, 32'h5);
		start(32'h0000_0100);
		// The ramp climbs one step a cycle, so the approach speed stands well before the cam.
		repeat (20) @(posedge clk);
		#1 chk(speed, DCHS_RST_SPEED);
		for (i = 0; i < 20000 && u_axis.pos < 150; i++) @(posedge clk);
		#1 chk(speed, DCHS_RST_CREEP);
		wait_done();
		chk({31'h0, busy}, 32'h0);
		chk(speed, 32'h0);
		chk(u_axis.pos == 197 || u_axis.pos == 198, 32'h1);
		rd_reg(DCHS_ADDR_POS); chk(v, 32'h0000_1234);
		rd_reg(DCHS_ADDR_REV_POS); chk(v, 32'(u_axis.pos - 192));
		wr_reg(DCHS_ADDR_CTRL, 32'h1);
		#1 chk({31'h0, done}, 32'h0);
	endtask
	task t_count;
		wr_reg(DCHS_ADDR_SHIFT, 32'h0);
		pol <= 1'b0;
		wr_reg(DCHS_ADDR_POST_DIST, 32'd20);
		wr_reg(DCHS_ADDR_HOME_POS, 32'h0000_0ABC);
		start(32'h0000_0011);
		wait_done();
		chk(u_axis.pos == 127 || u_axis.pos == 128, 32'h1);
		rd_reg(DCHS_ADDR_POS); chk(v, 32'h0000_0ABC);
		chk({31'h0, dir_neg}, 32'h1);
		wr_reg(DCHS_ADDR_CTRL, 32'h1);
	endtask
	task t_bad_method;
		start(32'h0000_0002);
		repeat (4) @(posedge clk);
		rd_reg(DCHS_ADDR_STATUS); chk(v & 32'h7, 32'h4);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		t_regs();
		t_manual();
		t_dog();
		t_count();
		t_bad_method();
		conclude();
	end
endmodule
`default_nettype wire
